// ===== common/dmx_pkg.sv
// types of the data-move instruction executor
`default_nettype none
package dmx_pkg;
	typedef enum logic [1:0]
	{
		DMX_Q1 = 2'h0,
		DMX_Q2 = 2'h1,
		DMX_Q3 = 2'h3,
		DMX_Q4 = 2'h2
	} dmx_phase_e;
	typedef logic [7:0] dmx_byte_t;
endpackage
`default_nettype wire

// ===== common/dmx_regs.svh
// constants of the data-move instruction executor
//
// Contract
// RULE_01 - peripheral move copies the source byte unchanged into destination
// RULE_02 - peripheral source spans 00h to 1Fh, destination spans 00h to FFh
// RULE_03 - working register may be source or destination of peripheral move
// RULE_04 - peripheral move opcode: top bits 010, 5-bit source, 8-bit destination
// RULE_05 - peripheral move updates zero flag only
// RULE_06 - one cycle: decode Q1, read Q2, execute Q3, write Q4
// RULE_07 - working move opcode upper byte 00000001, low byte is destination
// RULE_08 - working move takes one cycle and changes no status flag
`ifndef DMX_REGS_SVH
`define DMX_REGS_SVH

`define DMX_OP_PERIPH      3'h2
`define DMX_OP_PERIPH_HI   15
`define DMX_OP_PERIPH_LO   13
`define DMX_SRC_HI         12
`define DMX_SRC_LO         8
`define DMX_OP_WORKING     8'h01
`define DMX_OP_WORKING_HI  15
`define DMX_OP_WORKING_LO  8
`define DMX_DST_HI         7
`define DMX_DST_LO         0
`define DMX_WORKING_REGISTER_ADDR      8'h0A
`define DMX_ZERO_BYTE      8'h00

`endif

// ===== src/dmx_exec.sv
// decode and execution of the peripheral and working-register moves
`include "dmx_regs.svh"
`default_nettype none
module dmx_exec
	import dmx_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire logic [15:0] instr,
	input  wire logic        instr_valid,
	input  wire logic [7:0]  rd_data,
	output var  logic [7:0]  rd_addr,
	output var  logic        rd_en,
	output var  logic [7:0]  wr_addr,
	output var  logic [7:0]  wr_data,
	output var  logic        wr_en,
	output var  logic [7:0]  working_register,
	output var  logic        zero_flag,
	output var  logic [1:0]  phase
);

//////////////////////////////////////////////////////////////////////////////
function automatic logic is_periph(input logic [15:0] w);
	is_periph = w[`DMX_OP_PERIPH_HI:`DMX_OP_PERIPH_LO] == `DMX_OP_PERIPH;
endfunction

function automatic logic is_working(input logic [15:0] w);
	is_working = w[`DMX_OP_WORKING_HI:`DMX_OP_WORKING_LO] == `DMX_OP_WORKING;
endfunction

//////////////////////////////////////////////////////////////////////////////
dmx_phase_e phase_reg;
dmx_phase_e phase_next;
logic [15:0] ir_reg;
logic        periph_reg;
logic        working_reg;
dmx_byte_t   data_reg;
dmx_byte_t   working_register_reg;
logic        zero_reg;
logic [7:0]  rd_addr_reg;
logic        rd_en_reg;
logic [7:0]  wr_addr_reg;
logic [7:0]  wr_data_reg;
logic        wr_en_reg;

wire        dec_periph  = is_periph(instr);
wire        dec_working = is_working(instr);
wire [7:0]  src_addr    = {3'h0, ir_reg[`DMX_SRC_HI:`DMX_SRC_LO]};
wire [7:0]  dst_addr    = ir_reg[`DMX_DST_HI:`DMX_DST_LO];
wire        src_is_w    = src_addr == `DMX_WORKING_REGISTER_ADDR;
wire        dst_is_w    = dst_addr == `DMX_WORKING_REGISTER_ADDR;
// source byte as seen in q3; working register bypasses the memory read
wire [7:0]  src_byte    = src_is_w ? working_register_reg : rd_data;
wire [7:0]  move_byte   = periph_reg ? data_reg : working_register_reg;
wire        do_write    = phase_reg == DMX_Q4 && (periph_reg || working_reg);

// no default: all four codes of the two-bit phase are legal
always_comb
begin
	unique case (phase_reg)
		DMX_Q1: phase_next = DMX_Q2;
		DMX_Q2: phase_next = DMX_Q3;
		DMX_Q3: phase_next = DMX_Q4;
		DMX_Q4: phase_next = DMX_Q1;
	endcase
end

//////////////////////////////////////////////////////////////////////////////
// four-phase sequencer, held in q1 while reset
always_ff @(posedge mclk or negedge rstn)
begin
	if (!rstn)
		phase_reg <= DMX_Q1;
	else
		phase_reg <= phase_next; // RULE_06
end

// q1 decode: the instruction is taken only in q1
// decodes look at the live word; the register copy feeds q3 and q4
always_ff @(posedge mclk or negedge rstn)
begin
	if (!rstn)
	begin
		ir_reg      <= 16'h0000;
		periph_reg  <= 1'b0;
		working_reg <= 1'b0;
	end
	else if (phase_reg == DMX_Q1)
	begin
		ir_reg      <= instr;
		periph_reg  <= instr_valid && dec_periph;  // RULE_04
		working_reg <= instr_valid && dec_working; // RULE_07
	end
end

// q2 read strobe; the source field is only five bits wide
always_ff @(posedge mclk or negedge rstn)
begin
	if (!rstn)
	begin
		rd_addr_reg <= `DMX_ZERO_BYTE;
		rd_en_reg   <= 1'b0;
	end
	else
	begin
		rd_en_reg   <= phase_reg == DMX_Q1 && instr_valid && dec_periph;
		// held for the whole slot: the memory byte is fetched after q2
		if (phase_reg == DMX_Q1)
			rd_addr_reg <= {3'h0, instr[`DMX_SRC_HI:`DMX_SRC_LO]}; // RULE_02
	end
end

// q3 execute: latch data, set zero flag on the peripheral move only
always_ff @(posedge mclk or negedge rstn)
begin
	if (!rstn)
	begin
		data_reg <= `DMX_ZERO_BYTE;
		zero_reg <= 1'b0;
	end
	else if (phase_reg == DMX_Q3 && periph_reg) // RULE_08
	begin
		data_reg <= src_byte;                  // RULE_01 RULE_03
		zero_reg <= src_byte == `DMX_ZERO_BYTE; // RULE_05
	end
end

// q4 write; a working destination of the peripheral move also reloads the working register
always_ff @(posedge mclk or negedge rstn)
begin
	if (!rstn)
	begin
		wr_en_reg   <= 1'b0;
		wr_addr_reg <= `DMX_ZERO_BYTE;
		wr_data_reg <= `DMX_ZERO_BYTE;
		working_register_reg    <= `DMX_ZERO_BYTE;
	end
	else
	begin
		wr_en_reg <= do_write; // RULE_06
		if (do_write)
		begin
			wr_addr_reg <= dst_addr;  // RULE_02
			wr_data_reg <= move_byte; // RULE_01 RULE_07
			if (dst_is_w && periph_reg)
				working_register_reg <= move_byte; // RULE_03
		end
	end
end

assign rd_addr          = rd_addr_reg;
assign rd_en            = rd_en_reg;
assign wr_addr          = wr_addr_reg;
assign wr_data          = wr_data_reg;
assign wr_en            = wr_en_reg;
assign working_register = working_register_reg;
assign zero_flag        = zero_reg;
assign phase            = phase_reg;

//////////////////////////////////////////////////////////////////////////////
default clocking cb @(posedge mclk); endclocking
default disable iff (!rstn);

a_phase_order: assert property ( // RULE_06
	phase_reg == DMX_Q1 |=> phase_reg == DMX_Q2 ##1 phase_reg == DMX_Q3
		##1 phase_reg == DMX_Q4 ##1 phase_reg == DMX_Q1)
	else $error("phase order broken");
a_periph_timing: assert property ( // RULE_06
	phase_reg == DMX_Q1 && instr_valid && dec_periph |=> rd_en ##3 wr_en)
	else $error("peripheral move not one cycle");
a_src_range: assert property ( // RULE_02
	rd_en |-> rd_addr[7:5] == 3'h0)
	else $error("source out of range");
a_move_data: assert property ( // RULE_01
	phase_reg == DMX_Q3 && periph_reg && !src_is_w
		|=> ##1 wr_en && wr_data == $past(rd_data, 2))
	else $error("moved byte differs");
a_zero_set: assert property ( // RULE_05
	phase_reg == DMX_Q3 && periph_reg
		|=> ##1 zero_flag == (wr_data == `DMX_ZERO_BYTE))
	else $error("zero flag wrong");
a_zero_keep: assert property ( // RULE_08
	phase_reg == DMX_Q3 && !periph_reg |=> $stable(zero_flag))
	else $error("zero flag changed");
a_working_move: assert property ( // RULE_07
	phase_reg == DMX_Q1 && instr_valid && dec_working
		|=> ##3 wr_en && wr_data == $past(working_register, 3)
		&& wr_addr == $past(instr[7:0], 4))
	else $error("working move wrong");
a_working_register_load: assert property ( // RULE_03
	wr_en && $past(periph_reg) && wr_addr == `DMX_WORKING_REGISTER_ADDR
		|-> working_register == wr_data)
	else $error("working register not loaded");
a_no_spurious: assert property ( // RULE_04
	phase_reg == DMX_Q1 && !instr_valid |=> ##3 !wr_en)
	else $error("write without instruction");
a_rd_hold: assert property ( // RULE_01
	rd_en |=> $stable(rd_addr) [*2])
	else $error("read address moved during move");
a_rd_pulse: assert property ( // RULE_06
	rd_en |=> !rd_en)
	else $error("read strobe longer than one cycle");
a_wr_pulse: assert property ( // RULE_06
	wr_en |=> !wr_en)
	else $error("write strobe longer than one cycle");
a_working_flags: assert property ( // RULE_08
	phase_reg == DMX_Q1 && instr_valid && dec_working
		|=> ##3 zero_flag == $past(zero_flag, 4))
	else $error("working move changed zero flag");
a_working_register_keep: assert property ( // RULE_03
	wr_en && !($past(periph_reg) && wr_addr == `DMX_WORKING_REGISTER_ADDR)
		|-> $stable(working_register))
	else $error("working register changed without load");
a_no_read_working: assert property ( // RULE_07
	phase_reg == DMX_Q1 && instr_valid && dec_working |=> !rd_en)
	else $error("working move read memory");

// main scenarios: each move, zero result, working reload, refused word

c_periph: cover property (wr_en && $past(periph_reg));
c_working: cover property (wr_en && $past(working_reg));
c_zero: cover property ($rose(zero_flag));
c_working_register: cover property ($changed(working_register));
c_refused: cover property (
	phase_reg == DMX_Q1 && instr_valid && !dec_periph && !dec_working);

endmodule
`default_nettype wire

// ===== testbench/dmx_exec_tb.sv
// self-checking bench of the data-move instruction executor
`include "dmx_regs.svh"
`default_nettype none
module dmx_exec_tb
	import dmx_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk;
	logic        rstn;
	logic [15:0] instr;
	logic        instr_valid;
	logic [7:0]  rd_data;
	logic [7:0]  rd_addr;
	logic        rd_en;
	logic [7:0]  wr_addr;
	logic [7:0]  wr_data;
	logic        wr_en;
	logic [7:0]  working_register;
	logic        zero_flag;
	logic [1:0]  phase;
	logic [7:0]  mem [256];
	int          n_fail;
	int          check_count;

	dmx_exec dut (.mclk(mclk), .rstn(rstn), .instr(instr),
		.instr_valid(instr_valid), .rd_data(rd_data), .rd_addr(rd_addr),
		.rd_en(rd_en), .wr_addr(wr_addr), .wr_data(wr_data), .wr_en(wr_en),
		.working_register(working_register), .zero_flag(zero_flag),
		.phase(phase));

	initial
	begin
		mclk = 1'h0;
		forever #5 mclk = ~mclk;
	end
	// memory answers on the falling edge, so its byte is settled by Q3
	always @(negedge mclk)
		rd_data <= mem[rd_addr];

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [7:0] e,
		input logic [7:0] g);
	begin
		check_count++;
		if (g !== e)
		begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	end
	endtask

	// one instruction slot: entered and left at a Q1 falling edge
	task automatic op(input logic [15:0] w, input logic v, input logic rd,
		input logic wr, input logic [7:0] src, input logic [7:0] dst,
		input logic [7:0] dat, input logic zf);
	begin
		chk("phase", {6'h0, DMX_Q1}, {6'h0, phase});
		instr = w;
		instr_valid = v;
		@(negedge mclk);
		chk("rd_en", {7'h0, rd}, {7'h0, rd_en});
		if (rd)
			chk("rd_addr", src, rd_addr);
		// inverted word outside Q1 must be ignored
		instr = ~w;
		instr_valid = 1'h1;
		@(negedge mclk);
		instr_valid = 1'h0;
		repeat (2) @(negedge mclk);
		chk("wr_en", {7'h0, wr}, {7'h0, wr_en});
		if (wr)
		begin
			chk("wr_addr", dst, wr_addr);
			chk("wr_data", dat, wr_data);
		end
		chk("zero_flag", {7'h0, zf}, {7'h0, zero_flag});
	end
	endtask

	task automatic t_periph();
		op(16'h5FFF, 1'h1, 1'h1, 1'h1, 8'h1F, 8'hFF, 8'h5A, 1'h0);
		$display("periph boundary move done");
	endtask

	task automatic t_working_register();
	begin
		op(16'h430A, 1'h1, 1'h1, 1'h1, 8'h03, 8'h0A, 8'hC3, 1'h0);
		chk("working_register", 8'hC3, working_register);
		op(16'h4480, 1'h1, 1'h1, 1'h1, 8'h04, 8'h80, 8'h00, 1'h1);
		op(16'h0155, 1'h1, 1'h0, 1'h1, 8'h00, 8'h55, 8'hC3, 1'h1);
		op(16'h4A20, 1'h1, 1'h1, 1'h1, 8'h0A, 8'h20, 8'hC3, 1'h0);
		$display("working register moves done");
	end
	endtask

	task automatic t_refuse();
	begin
		op(16'h5FFF, 1'h0, 1'h0, 1'h0, 8'h00, 8'h00, 8'h00, 1'h0);
		op(16'h6000, 1'h1, 1'h0, 1'h0, 8'h00, 8'h00, 8'h00, 1'h0);
		op(16'h0255, 1'h1, 1'h0, 1'h0, 8'h00, 8'h00, 8'h00, 1'h0);
		$display("refused words done");
	end
	endtask

	// reset in mid-move abandons it; the word after release is taken
	task automatic t_reset();
	begin
		instr = 16'h5F33;
		instr_valid = 1'h1;
		@(negedge mclk);
		instr_valid = 1'h0;
		rstn = 1'h0;
		@(negedge mclk);
		chk("phase", {6'h0, DMX_Q1}, {6'h0, phase});
		chk("rd_en", 8'h00, {7'h0, rd_en});
		chk("wr_en", 8'h00, {7'h0, wr_en});
		chk("working_register", 8'h00, working_register);
		chk("zero_flag", 8'h00, {7'h0, zero_flag});
		rstn = 1'h1;
		op(16'h0112, 1'h1, 1'h0, 1'h1, 8'h00, 8'h12, 8'h00, 1'h0);
		$display("mid-run reset done");
	end
	endtask

	task automatic final_report();
	begin
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	end
	endtask

	initial
	begin
		#5000;
		n_fail++;
		final_report();
	end

	initial
	begin
		n_fail = 0;
		check_count = 0;
		rstn = 1'h0;
		instr = 16'h0000;
		instr_valid = 1'h0;
		for (int i = 0; i < 256; i++)
			mem[i] = 8'hA5 ^ i[7:0];
		mem[8'h1F] = 8'h5A;
		mem[8'h03] = 8'hC3;
		mem[8'h04] = 8'h00;
		mem[8'h0A] = 8'h11;
		repeat (16) @(negedge mclk);
		// reset holds the phase in Q1, so the first word follows at once
		rstn = 1'h1;
		t_periph();
		t_working_register();
		t_refuse();
		t_reset();
		final_report();
	end
endmodule
`default_nettype wire
